// ---- tb.sv ----
// Purpose: Self-checking bench for the sequencer input block
// Assumes: 10 MHz hclk, reads scored from a queue of notes
// Notes: Timer shortened to 20 cycles to keep the run brief
`timescale 1ns/100ps
module tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic mts, kfr, bp, ins, prot, loc, slow, txa, mclk, aclk, uload;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  tps_pkg::tps_seq_cmd_e seq_cmd;
  logic [3:0] seq_value, op;
  logic [6:0] byte_lines;
  // One-shot qualifiers, bit order as wired below
  logic [16:0] ctl;
  // Expected register image
  logic [3:0] e_seq, e_opn;
  logic e_mode, e_esc, e_fmt, e_lock, e_tmr;
  logic [4:0] e_line, e_roll;
  logic [6:0] e_col;
  // Read notes and masks, oldest first
  logic [31:0] exp_q[$], msk_q[$], e, m;
  logic rd_pend;
  int failures, samples_checked, cyc, n;
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  tps_core #(.TIMER_CYCLES(20)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .master_timing_strobe(mts), .seq_cmd, .seq_value, .byte_lines,
    .byte_present(bp), .esc_clear(ctl[0]), .insert_select(ins),
    .cell_protected(prot), .format_clock(ctl[1]), .lockout_clock(ctl[2]),
    .timer_start(ctl[3]), .transmitter_active(txa),
    .line_count_up(ctl[4]), .line_count_down(ctl[5]), .line_clear(ctl[6]),
    .column_count_up(ctl[7]), .column_count_down(ctl[8]),
    .column_clear(ctl[9]), .saved_load(ctl[10]),
    .saved_line_dec(ctl[11]), .saved_column_dec(ctl[12]),
    .roll_up(ctl[13]), .key_strobe(ctl[14]), .kb_escape_set(ctl[15]),
    .keyboard_full_reset(kfr), .local_only_key_op(loc),
    .tx_load_req(ctl[16]), .main_serial_clock_x16(mclk),
    .aux_serial_clock_x16(aclk), .pla_inputs(), .step_count_bits(),
    .operation_code_bits(), .escape_pending(), .keyboard_lockout(),
    .key_accept(), .uart_load(uload), .uart_clock_x16(), .cursor_line(),
    .cursor_column(), .display_start(), .roll_at_max()
  );
  tps_far_model far (.hclk, .hresetn, .uart_load(uload), .slow,
    .transmitter_active(txa), .main_serial_clock_x16(mclk),
    .aux_serial_clock_x16(aclk));
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Single word transfer; held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] k);
    exp_q.push_back(x);
    msk_q.push_back(k);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // One strobe with its qualifiers; levels get fresh random values
  task automatic stb(input tps_pkg::tps_seq_cmd_e c, input logic [3:0] v,
      input logic [16:0] k);
    mts <= 1'b1;
    seq_cmd <= c;
    seq_value <= v;
    ctl <= k;
    ins <= 1'($urandom);
    prot <= 1'($urandom);
    @(posedge hclk);
    mts <= 1'b0;
    seq_cmd <= tps_pkg::TPS_SEQ_HOLD;
    ctl <= '0;
    // Idle edge so a following strobe never reassigns in one step
    @(posedge hclk);
  endtask
  task automatic chk_st(input logic [31:0] k);
    rd(8'h04, {18'h0, e_roll == 5'h17, e_tmr, e_lock, e_fmt, e_esc, e_opn,
      e_mode, e_seq}, k);
  endtask
  task automatic chk_cur;
    rd(8'h08, {11'h0, e_roll, 1'b0, e_col, 3'h0, e_line}, '1);
  endtask
  task automatic clr_exp;
    {e_seq, e_opn, e_mode, e_esc, e_fmt, e_lock, e_tmr} = '0;
    {e_line, e_roll, e_col} = '0;
  endtask
  // Scoreboard: a read's data appears at the edge after its address
  always @(posedge hclk) begin
    if (rd_pend) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      cmp(hrdata & m, e & m);
    end
    rd_pend <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  // Hang guard, well above the expected run
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    {hresetn, hsel, hwrite, mts, kfr, bp, ins, prot, loc, slow} = '0;
    {haddr, htrans, hsize, hwdata, seq_value, byte_lines, ctl} = '0;
    seq_cmd = tps_pkg::TPS_SEQ_HOLD;
    rd_pend = 1'b0;
    clr_exp();
    n = $urandom(98);
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_st('1);
    chk_cur();
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'h0, '1);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h1, '1);
    // escape by code then by keyboard
    byte_lines <= 7'h1b;
    bp <= 1'b1;
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, '0);
    bp <= 1'b0;
    e_esc = 1'b1;
    chk_st('1);
    wr(8'h00, 32'h3);
    e_esc = 1'b0;
    chk_st('1);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h08000);
    e_esc = 1'b1;
    chk_st('1);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00001);
    e_esc = 1'b0;
    // flops follow step bit zero, lockout blocks keys
    stb(tps_pkg::TPS_SEQ_LOAD, 4'h1, 17'h0);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00006);
    {e_seq, e_fmt, e_lock} = {4'h1, 2'b11};
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h0c000);
    chk_st('1);
    stb(tps_pkg::TPS_SEQ_LOAD, 4'h0, 17'h0);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h04004);
    {e_seq, e_lock} = '0;
    chk_st('1);
    // step count wraps after fifteen, key taken unlocked
    stb(tps_pkg::TPS_SEQ_LOAD, 4'hf, 17'h04000);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h0);
    e_seq = 4'hf;
    chk_st('1);
    stb(tps_pkg::TPS_SEQ_NEXT, 4'h0, 17'h0);
    e_seq = 4'h0;
    chk_st('1);
    // operation load enters execution at step zero
    op = 4'($urandom_range(1, 14));
    stb(tps_pkg::TPS_SEQ_LDOP, op, 17'h0);
    stb(tps_pkg::TPS_SEQ_NEXT, 4'h0, 17'h0);
    {e_mode, e_opn, e_seq} = {1'b1, op, 4'h1};
    chk_st('1);
    e_line = 5'($urandom_range(1, 23));
    e_col = 7'($urandom_range(1, 79));
    repeat (e_line) stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00010);
    repeat (e_col) stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00080);
    chk_cur();
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00120);
    e_line = e_line - 5'h01;
    e_col = e_col - 7'h01;
    chk_cur();
    repeat (7'h50 - e_col) stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00080);
    e_col = 7'h50;
    chk_cur();
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00240);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h00400);
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h01800);
    {e_line, e_col} = '0;
    chk_cur();
    // all-high operation with the timer fired
    stb(tps_pkg::TPS_SEQ_LDOP, 4'hf, 17'h00008);
    {e_opn, e_seq, e_tmr} = {4'hf, 4'h0, 1'b1};
    chk_st('1);
    repeat (30) @(posedge hclk);
    e_tmr = 1'b0;
    chk_st('1);
    stb(tps_pkg::TPS_SEQ_GOIDLE, 4'h0, 17'h0);
    stb(tps_pkg::TPS_SEQ_CLEAR, 4'h0, 17'h0);
    {e_mode, e_seq} = '0;
    chk_st(32'hfffffe1f);
    repeat (23) stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h02000);
    e_roll = 5'h17;
    chk_st(32'hfffffe1f);
    chk_cur();
    stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h02000);
    e_roll = 5'h00;
    chk_cur();
    // random byte, null byte, local-only byte
    for (n = 0; n < 3; n++) begin
      slow <= 1'($urandom);
      byte_lines <= (n == 1) ? 7'h00 : 7'($urandom_range(1, 127));
      loc <= (n == 2);
      stb(tps_pkg::TPS_SEQ_HOLD, 4'h0, 17'h10000);
      repeat (70) @(posedge hclk);
    end
    loc <= 1'b0;
    kfr <= 1'b1;
    @(posedge hclk);
    kfr <= 1'b0;
    clr_exp();
    chk_st('1);
    chk_cur();
    rd(8'h00, 32'h0, '1);
    @(posedge hclk);
    end_sim();
  end
endmodule // tb

// ---- tps_core.sv ----
// Purpose: Condition inputs and counters of the array sequencer
// Assumes: All inputs synchronous to hclk, strobe is one cycle
// Notes: Registers reached over AHB-Lite with no wait states
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "tps_params.svh"

// Operation
// - Four step bits feed array, both modes
// - Sixteen steps per mode and operation
// - Mode bit selects term interpretation
// - Escape flag set by code or keyboard
// - Insert select passed in idle mode
// - Seven byte bits decoded in idle mode
// - Format level passed in execution mode
// - Illegal off screen or underflow pulse
// - Operation bits weighted 1,2,4,8
// - Timer carry low during timeout, high after it until a strobe, else pulses
// - Protect needs format and protected byte
// - Transmitter active passed while sending
// - Each scroll step moves start 80
// - Scroll count 23 flags and wraps
// - Separate line and column increments
// - Lockout ignores keyboard entry
// - Keyboard full reset clears everything
// - Serial timing from x16 clock
// - UART clock chosen main or auxiliary
// - Null bytes never transmitted
// - Local-only keyboard ops not transmitted
// - Updates timed to master strobe, except timer countdown, key accept, keyboard full reset and bus writes
// - Cursor line counts 0 to 23
// - Cursor column counts 0 to 79
module tps_core #(
  parameter int unsigned TIMER_CYCLES = `TPS_TIMER_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic master_timing_strobe,
  input wire tps_pkg::tps_seq_cmd_e seq_cmd,
  input wire logic [3:0] seq_value,
  input wire logic [6:0] byte_lines,
  input wire logic byte_present,
  input wire logic esc_clear,
  input wire logic insert_select,
  input wire logic cell_protected,
  input wire logic format_clock,
  input wire logic lockout_clock,
  input wire logic timer_start,
  input wire logic transmitter_active,
  input wire logic line_count_up,
  input wire logic line_count_down,
  input wire logic line_clear,
  input wire logic column_count_up,
  input wire logic column_count_down,
  input wire logic column_clear,
  input wire logic saved_load,
  input wire logic saved_line_dec,
  input wire logic saved_column_dec,
  input wire logic roll_up,
  input wire logic key_strobe,
  input wire logic kb_escape_set,
  input wire logic keyboard_full_reset,
  input wire logic local_only_key_op,
  input wire logic tx_load_req,
  input wire logic main_serial_clock_x16,
  input wire logic aux_serial_clock_x16,
  output logic [13:0] pla_inputs,
  output logic [3:0] step_count_bits,
  output logic [3:0] operation_code_bits,
  output logic escape_pending,
  output logic keyboard_lockout,
  output logic key_accept,
  output logic uart_load,
  output logic uart_clock_x16,
  output logic [4:0] cursor_line,
  output logic [6:0] cursor_column,
  output logic [10:0] display_start,
  output logic roll_at_max
);

  // Full reset from the keyboard acts like a synchronous clear
  logic kill;
  // Strobe qualifier shared by sequencer, flag, cursor and UART load updates
  logic stb;
  assign stb = master_timing_strobe & ~keyboard_full_reset;
  assign kill = keyboard_full_reset;

  // ---------------- Sequencer state ----------------
  tps_pkg::tps_mode_e mode_ff, nxt_mode;
  logic [3:0] seq_ff, nxt_seq; // program counter
  logic [3:0] opn_ff, nxt_opn; // current operation

  // Next sequence, mode and operation
  always_comb begin
    nxt_mode = mode_ff;
    nxt_seq = seq_ff;
    nxt_opn = opn_ff;
    if (kill) begin
      nxt_mode = tps_pkg::TPS_IDLE;
      nxt_seq = 4'h0;
      nxt_opn = 4'h0;
    end else if (stb) begin
      case (seq_cmd)
        // sixteen steps, counter wraps after 15
        tps_pkg::TPS_SEQ_NEXT: nxt_seq = seq_ff + 4'h1;
        tps_pkg::TPS_SEQ_LOAD: nxt_seq = seq_value;
        tps_pkg::TPS_SEQ_CLEAR: nxt_seq = 4'h0;
        tps_pkg::TPS_SEQ_LDOP: begin
          // Loading an operation moves into execution mode
          nxt_opn = seq_value;
          nxt_mode = tps_pkg::TPS_EXEC;
          nxt_seq = 4'h0;
        end
        tps_pkg::TPS_SEQ_GOIDLE: begin
          nxt_mode = tps_pkg::TPS_IDLE;
          nxt_seq = 4'h0;
        end
        tps_pkg::TPS_SEQ_HOLD: nxt_seq = seq_ff;
        default: nxt_seq = seq_ff;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= tps_pkg::TPS_IDLE;
      seq_ff <= 4'h0;
      opn_ff <= 4'h0;
    end else begin
      mode_ff <= nxt_mode;
      seq_ff <= nxt_seq;
      opn_ff <= nxt_opn;
    end
  end

  // ---------------- Flags ----------------
  logic esc_ff, nxt_esc; // escape lead-in seen
  logic fmt_ff, nxt_fmt; // format mode on
  logic lock_ff, nxt_lock; // keyboard locked out
  logic sw_esc_clr; // software clear of escape flag
  logic esc_hit; // escape code decoded on the bus
  logic kb_ok; // keyboard entry allowed

  assign kb_ok = ~lock_ff;
  assign esc_hit = byte_present & (byte_lines == `TPS_ESC_CODE) &
                   (mode_ff == tps_pkg::TPS_IDLE);

  // Flag updates; a set beats a clear in the same cycle
  always_comb begin
    nxt_esc = esc_ff;
    nxt_fmt = fmt_ff;
    nxt_lock = lock_ff;
    if (kill) begin
      nxt_esc = 1'b0;
      nxt_fmt = 1'b0;
      nxt_lock = 1'b0;
    end else begin
      if (sw_esc_clr | (stb & esc_clear))
        nxt_esc = 1'b0;
      if (stb & (esc_hit | (kb_escape_set & kb_ok)))
        nxt_esc = 1'b1;
      // Set or clear chosen by the step counter's low bit
      if (stb & format_clock)
        nxt_fmt = seq_ff[0];
      if (stb & lockout_clock)
        nxt_lock = seq_ff[0];
    end
  end

  // Flag registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      esc_ff <= 1'b0;
      fmt_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      esc_ff <= nxt_esc;
      fmt_ff <= nxt_fmt;
      lock_ff <= nxt_lock;
    end
  end

  // ---------------- Cursor and scroll ----------------
  logic [4:0] line_ff, nxt_line; // cursor line
  logic [6:0] col_ff, nxt_col; // cursor column
  logic [4:0] sline_ff, nxt_sline; // saved line count
  logic [6:0] scol_ff, nxt_scol; // saved column count
  logic luf_ff, nxt_luf; // saved line has underflowed
  logic ufp_ff, nxt_ufp; // one-cycle underflow pulse
  logic [4:0] roll_ff, nxt_roll; // scroll counter
  logic offscr; // cursor off the displayable screen

  assign offscr = (line_ff > `TPS_LINE_MAX) | (col_ff > `TPS_COL_MAX);

  // Counter updates; moving past an edge leaves the count off screen
  // so the program can see it and correct the cursor itself
  always_comb begin
    nxt_line = line_ff;
    nxt_col = col_ff;
    nxt_sline = sline_ff;
    nxt_scol = scol_ff;
    nxt_luf = luf_ff;
    nxt_ufp = 1'b0;
    nxt_roll = roll_ff;
    if (kill) begin
      nxt_line = 5'h00;
      nxt_col = 7'h00;
      nxt_sline = 5'h00;
      nxt_scol = 7'h00;
      nxt_luf = 1'b0;
      nxt_roll = 5'h00;
    end else if (stb) begin
      if (line_clear)
        nxt_line = 5'h00;
      else if (line_count_up)
        nxt_line = line_ff + 5'h01;
      else if (line_count_down)
        nxt_line = line_ff - 5'h01;
      if (column_clear)
        nxt_col = 7'h00;
      else if (column_count_up)
        nxt_col = col_ff + 7'h01;
      else if (column_count_down)
        nxt_col = col_ff - 7'h01;
      if (saved_load) begin
        nxt_sline = line_ff;
        nxt_scol = col_ff;
        nxt_luf = 1'b0;
      end else begin
        if (saved_line_dec & ~luf_ff) begin
          nxt_sline = sline_ff - 5'h01;
          if (sline_ff == 5'h00) begin
            nxt_luf = 1'b1;
            nxt_ufp = 1'b1;
          end
        end
        // Column counts only once the line has been reached
        if (saved_column_dec & luf_ff) begin
          nxt_scol = scol_ff - 7'h01;
          if (scol_ff == 7'h00)
            nxt_ufp = 1'b1;
        end
      end
      if (roll_up)
        nxt_roll = (roll_ff == `TPS_ROLL_MAX) ? 5'h00 :
                   roll_ff + 5'h01;
    end
  end

  // Cursor and scroll registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_ff <= 5'h00;
      col_ff <= 7'h00;
      sline_ff <= 5'h00;
      scol_ff <= 7'h00;
      luf_ff <= 1'b0;
      ufp_ff <= 1'b0;
      roll_ff <= 5'h00;
    end else begin
      line_ff <= nxt_line;
      col_ff <= nxt_col;
      sline_ff <= nxt_sline;
      scol_ff <= nxt_scol;
      luf_ff <= nxt_luf;
      ufp_ff <= nxt_ufp;
      roll_ff <= nxt_roll;
    end
  end

  // ---------------- Timeout timer ----------------
  logic [18:0] tcnt_ff, nxt_tcnt; // cycles left in the timeout
  logic trun_ff, nxt_trun; // timeout in progress
  logic tdone_ff, nxt_tdone; // timeout just ended, carry held high
  logic carry; // carry term to the array

  always_comb begin
    nxt_tcnt = tcnt_ff;
    nxt_trun = trun_ff;
    nxt_tdone = tdone_ff;
    if (kill) begin
      nxt_trun = 1'b0;
      nxt_tdone = 1'b0;
      nxt_tcnt = 19'h00000;
    end else if (stb & timer_start) begin
      nxt_trun = 1'b1;
      nxt_tdone = 1'b0;
      nxt_tcnt = 19'(TIMER_CYCLES - 1);
    end else if (trun_ff) begin
      // Timer counts every cycle, not only on strobes
      if (tcnt_ff == 19'h00000) begin
        nxt_trun = 1'b0;
        nxt_tdone = 1'b1;
      end else begin
        nxt_tcnt = tcnt_ff - 19'h00001;
      end
    end else if (stb) begin
      // End level is consumed by the next strobe
      nxt_tdone = 1'b0;
    end
  end

  // Timer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt_ff <= 19'h00000;
      trun_ff <= 1'b0;
      tdone_ff <= 1'b0;
    end else begin
      tcnt_ff <= nxt_tcnt;
      trun_ff <= nxt_trun;
      tdone_ff <= nxt_tdone;
    end
  end

  // Idle timer lets the carry follow the strobe as a pulse
  assign carry = ~trun_ff & (tdone_ff | master_timing_strobe);

  // ---------------- Array inputs and outputs ----------------
  logic [13:0] nxt_pla, pla_ff; // assembled array word
  logic aux_sel_ff, nxt_aux_sel; // UART clock source choice
  logic clk_ff, nxt_clk; // selected x16 clock
  logic uld_ff, nxt_uld; // UART load after filtering
  logic key_ff, nxt_key; // accepted key strobe

  always_comb begin
    if (mode_ff == tps_pkg::TPS_IDLE) begin
      nxt_pla = {seq_ff, esc_ff, 1'b0, insert_select, byte_lines};
    end else begin
      nxt_pla = {seq_ff, fmt_ff, 1'b1, offscr | ufp_ff, opn_ff,
                 carry, fmt_ff & cell_protected, transmitter_active};
    end
  end

  // Serial side filtering and clock choice
  always_comb begin
    nxt_clk = aux_sel_ff ? aux_serial_clock_x16 : main_serial_clock_x16;
    nxt_uld = stb & tx_load_req & (byte_lines != 7'h00) &
              ~local_only_key_op;
    nxt_key = key_strobe & kb_ok & ~kill;
  end

  // Output registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pla_ff <= 14'h0000;
      clk_ff <= 1'b0;
      uld_ff <= 1'b0;
      key_ff <= 1'b0;
    end else begin
      pla_ff <= nxt_pla;
      clk_ff <= nxt_clk;
      uld_ff <= nxt_uld;
      key_ff <= nxt_key;
    end
  end

  assign pla_inputs = pla_ff;
  assign step_count_bits = seq_ff;
  assign operation_code_bits = opn_ff;
  assign escape_pending = esc_ff;
  assign keyboard_lockout = lock_ff;
  assign key_accept = key_ff;
  assign uart_load = uld_ff;
  assign uart_clock_x16 = clk_ff;
  assign cursor_line = line_ff;
  assign cursor_column = col_ff;
  assign display_start = 11'(roll_ff * `TPS_ROLL_STEP);
  assign roll_at_max = (roll_ff == `TPS_ROLL_MAX);

  // ---------------- AHB-Lite slave ----------------
  logic wr_ff, nxt_wr; // write data phase pending
  logic [7:0] wad_ff, nxt_wad; // address of the pending write
  logic [31:0] rd_ff, nxt_rd; // read data for the data phase
  logic take; // address phase accepted

  assign take = hsel & htrans[1] & hready;

  // Address decode, read capture and write completion
  always_comb begin
    nxt_wr = take & hwrite;
    nxt_wad = take ? haddr : wad_ff;
    nxt_rd = 32'h00000000;
    nxt_aux_sel = aux_sel_ff;
    sw_esc_clr = 1'b0;
    if (take & ~hwrite) begin
      case (haddr)
        `TPS_OFF_CTRL: nxt_rd = {31'h00000000, aux_sel_ff};
        `TPS_OFF_STATUS:
          nxt_rd = {18'h00000, roll_at_max, trun_ff, lock_ff, fmt_ff,
                    esc_ff, opn_ff, mode_ff, seq_ff};
        `TPS_OFF_CURSOR:
          nxt_rd = {11'h000, roll_ff, 1'b0, col_ff, 3'h0, line_ff};
        // Unmapped addresses read zero
        default: nxt_rd = 32'h00000000;
      endcase
    end
    // Only the control word is writable
    if (wr_ff & (wad_ff == `TPS_OFF_CTRL)) begin
      nxt_aux_sel = hwdata[`TPS_CTRL_AUXSEL];
      sw_esc_clr = hwdata[`TPS_CTRL_ESCCLR];
    end
    if (kill)
      nxt_aux_sel = 1'b0;
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wad_ff <= 8'h00;
      rd_ff <= 32'h00000000;
      aux_sel_ff <= 1'b0;
    end else begin
      wr_ff <= nxt_wr;
      wad_ff <= nxt_wad;
      rd_ff <= nxt_rd;
      aux_sel_ff <= nxt_aux_sel;
    end
  end

  // Never stalls and never errors; hsize is not checked
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_ff;

endmodule // tps_core

// ---- tps_core_checker.sv ----
// Purpose: Port-level checks of the sequencer input block
// Assumes: One hclk domain, hresetn async active low
// Notes: Timer length is passed on but checked only over 8 cycles
`timescale 1ns/100ps
module tps_core_checker #(
  parameter int unsigned TIMER_CYCLES = 300000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic master_timing_strobe,
  input wire logic tx_load_req,
  input wire logic [6:0] byte_lines,
  input wire logic local_only_key_op,
  input wire logic key_strobe,
  input wire logic keyboard_lockout,
  input wire logic key_accept,
  input wire logic uart_load,
  input wire logic keyboard_full_reset,
  input wire logic timer_start,
  input wire logic [13:0] pla_inputs,
  input wire logic [3:0] step_count_bits,
  input wire logic [3:0] operation_code_bits,
  input wire logic escape_pending,
  input wire logic [4:0] cursor_line,
  input wire logic [6:0] cursor_column,
  input wire logic line_count_up,
  input wire logic line_clear,
  input wire logic roll_up,
  input wire logic roll_at_max,
  input wire logic [10:0] display_start
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Array inputs lag the registers by one edge
  chk_step_feed: assert property (
    !$past(keyboard_full_reset)
    |-> pla_inputs[13:10] == $past(step_count_bits))
    else $error("step bits not fed to array");
  chk_idle_esc: assert property (
    !pla_inputs[8] && !$past(keyboard_full_reset)
    |-> pla_inputs[9] == $past(escape_pending))
    else $error("escape flag missing in idle terms");
  chk_exec_opn: assert property (
    pla_inputs[8] && !$past(keyboard_full_reset)
    |-> pla_inputs[6:3] == $past(operation_code_bits))
    else $error("operation bits wrong in execution terms");
  chk_off_screen: assert property (
    pla_inputs[8] && !$past(keyboard_full_reset) &&
    $past(cursor_column) > 7'h4f |-> pla_inputs[7])
    else $error("off-screen cursor not flagged");
  chk_carry_low: assert property (
    master_timing_strobe && timer_start && pla_inputs[8] &&
    !keyboard_full_reset |-> ##2 (!pla_inputs[2] || !pla_inputs[8]) [*8])
    else $error("carry not held low during timeout");
  chk_key_gate: assert property (
    key_accept |-> $past(key_strobe) && !$past(keyboard_lockout))
    else $error("key accepted while locked out");
  chk_null_drop: assert property (
    uart_load |-> $past(master_timing_strobe && tx_load_req &&
    byte_lines != 7'h00 && !local_only_key_op))
    else $error("null or local byte sent to uart");
  // A plain byte request must reach the transmitter one edge later
  chk_load_sent: assert property (
    master_timing_strobe && tx_load_req && byte_lines != 7'h00 &&
    !local_only_key_op && !keyboard_full_reset |=> uart_load)
    else $error("valid byte not loaded into uart");
  chk_roll_step: assert property (
    master_timing_strobe && roll_up && !roll_at_max && !keyboard_full_reset
    |=> display_start == $past(display_start) + 11'h050)
    else $error("scroll step is not 80 positions");
  chk_roll_max: assert property (
    roll_at_max |-> display_start == 11'h730)
    else $error("wrap flag away from count 23");
  chk_line_up: assert property (
    master_timing_strobe && line_count_up && !line_clear &&
    !keyboard_full_reset |=> cursor_line == $past(cursor_line) + 5'h01)
    else $error("line count did not step up");
  // Only the timer, key accept, keyboard full reset and bus writes move state between strobes
  chk_no_strobe: assert property (
    !master_timing_strobe && !keyboard_full_reset |=> $stable(step_count_bits)
    && $stable(cursor_line) && $stable(operation_code_bits))
    else $error("state changed without strobe");
  cov_uart: cover property (uart_load);
  cov_key: cover property (key_accept);
  cov_wrap: cover property (master_timing_strobe && roll_up && roll_at_max);
endmodule // tps_core_checker

bind tps_core tps_core_checker #(.TIMER_CYCLES(TIMER_CYCLES)) u_chk (
  .hclk, .hresetn, .master_timing_strobe, .tx_load_req, .byte_lines,
  .local_only_key_op, .key_strobe, .keyboard_lockout, .key_accept,
  .uart_load, .keyboard_full_reset, .timer_start, .pla_inputs,
  .step_count_bits, .operation_code_bits, .escape_pending, .cursor_line,
  .cursor_column, .line_count_up, .line_clear, .roll_up, .roll_at_max,
  .display_start
);

// ---- tps_far_model.sv ----
// Purpose: Far-side model of UART transmitter and baud sources
// Assumes: Runs on hclk, reset active low
// Notes: slow stretches each byte to stall the transmitter
`timescale 1ns/100ps
module tps_far_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic uart_load,
  input wire logic slow,
  output logic transmitter_active,
  output logic main_serial_clock_x16,
  output logic aux_serial_clock_x16
);
  // Cycles left on the byte being sent
  logic [5:0] busy_ff;
  // Free divider; both baud sources run continuously
  logic [2:0] div_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff <= 6'h00;
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
      if (uart_load) begin
        busy_ff <= slow ? 6'h3f : 6'h08;
      end else if (busy_ff != 6'h00) begin
        busy_ff <= busy_ff - 6'h01;
      end
    end
  end
  assign transmitter_active = busy_ff != 6'h00;
  assign main_serial_clock_x16 = div_ff[0];
  assign aux_serial_clock_x16 = div_ff[2];
endmodule // tps_far_model

// ---- tps_params.svh ----
// Purpose: Constants for the sequencer input block
// Assumes: 10 MHz hclk
// Notes: Offsets are byte addresses on the register bus
`ifndef TPS_PARAMS_SVH
`define TPS_PARAMS_SVH
`define TPS_CLK_KHZ 10000
`define TPS_TIMER_MS 30
`define TPS_TIMER_CYC (`TPS_TIMER_MS * `TPS_CLK_KHZ)
`define TPS_OFF_CTRL 8'h00
`define TPS_OFF_STATUS 8'h04
`define TPS_OFF_CURSOR 8'h08
`define TPS_CTRL_AUXSEL 0
`define TPS_CTRL_ESCCLR 1
`define TPS_ESC_CODE 7'h1b
`define TPS_LINE_MAX 5'h17
`define TPS_COL_MAX 7'h4f
`define TPS_ROLL_MAX 5'h17
`define TPS_ROLL_STEP 11'h050
`endif

// ---- tps_pkg.sv ----
// Purpose: Types shared by the sequencer input block
// Assumes: Nothing beyond SystemVerilog
// Notes: Sequencer commands arrive as one code per strobe
package tps_pkg;
  // Operating mode of the logic array
  typedef enum logic {
    TPS_IDLE = 1'b0,
    TPS_EXEC = 1'b1
  } tps_mode_e;
  // Sequence counter commands
  typedef enum logic [2:0] {
    TPS_SEQ_HOLD = 3'b000,
    TPS_SEQ_NEXT = 3'b001,
    TPS_SEQ_LOAD = 3'b010,
    TPS_SEQ_CLEAR = 3'b011,
    TPS_SEQ_LDOP = 3'b100,
    TPS_SEQ_GOIDLE = 3'b101
  } tps_seq_cmd_e;
endpackage
